// file: rtl/gpio_mux_pkg.sv
// constants, types and select decoding for the general-purpose pin mux
// assumes configuration words arrive already registered by their owners
`default_nettype none
package gpio_mux_pkg;
    localparam int NUM_GPI = 22;
    localparam int NUM_GPO = 24;
    localparam int NUM_DRIVE = 31;
    // pm i/o space offsets
    localparam logic [7:0] IN_LEVEL_OFS  = 8'h30;
    localparam logic [7:0] OUT_DRIVE_OFS = 8'h34;
    // general configuration bit positions
    localparam int CFG_EIO_BIT    = 0;
    localparam int CFG_DMA_LO_BIT = 8;
    localparam int CFG_RTC_BIT    = 14;
    localparam int CFG_ALERT_BIT  = 15;
    localparam int CFG_SERIAL_INTERRUPT_LINE_BIT = 16;
    localparam int CFG_SUSBC_BIT  = 17;
    localparam int CFG_CPUSTP_BIT = 18;
    localparam int CFG_PCISTP_BIT = 19;
    localparam int CFG_SLEEP_BIT  = 20;
    localparam int CFG_STAT1_BIT  = 21;
    localparam int CFG_STAT2_BIT  = 22;
    localparam int CFG_THERMAL_ALARM_INPUT_BIT   = 23;
    localparam int CFG_BATTERY_LOW_INPUT_BIT = 24;
    localparam int CFG_LID_BIT    = 25;
    localparam int CFG_RING_BIT   = 27;
    localparam int CFG_XBUS_BIT   = 28;
    localparam logic EIO_SEL      = 1'b0;
    // reset values
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [31:0] DRIVE_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
    localparam logic [NUM_GPI-1:0] SYNC_RESET = 22'h000000;

    typedef struct packed {
        logic [NUM_GPI-1:0] meta;
        logic [NUM_GPI-1:0] stable;
    } sync_state_t;

    // values that alternate functions want on shared output pins
    typedef struct packed {
        logic [6:0] upper_isa_address_lines;
        logic [2:0] dma_grant;
        logic       ext_intr_ctrl_acknowledge;
        logic       ext_intr_ctrl_chip_select;
        logic       timer_interrupt_output;
        logic       suspend_plane_b_control;
        logic       suspend_plane_c_control;
        logic       processor_clock_stop;
        logic       bus_clock_stop;
        logic       cache_sram_sleep;
        logic       suspend_status_one;
        logic       suspend_status_two;
        logic       xbus_transceiver_direction;
        logic       xbus_transceiver_output_enable;
    } alt_out_t;

    // shared input pins handed to alternate functions
    typedef struct packed {
        logic       io_channel_check;
        logic [2:0] dma_request;
        logic       ext_intr_ctrl_request;
        logic       clock_chip_interrupt_input;
        logic       serial_interrupt_line;
        logic       thermal_alarm_input;
        logic       battery_low_input;
        logic       lid_switch_input;
        logic       smbus_alert_input;
        logic       ring_indicate_input;
    } alt_in_t;

    localparam alt_in_t ALT_IN_IDLE = 12'hfff;

    // one bit per input pin, high when the pin is a plain input
    function automatic logic [NUM_GPI-1:0] gpi_select(
        input logic [31:0] cfg,
        input logic        ext_apic
    );
        logic [NUM_GPI-1:0] s;
        s = '1;
        s[0] = (cfg[CFG_EIO_BIT] == EIO_SEL);
        for (int k = 0; k < 3; k++) begin
            s[2+k] = ~cfg[CFG_DMA_LO_BIT+k];
        end
        s[5]  = ~ext_apic;
        s[6]  = ~cfg[CFG_RTC_BIT];
        s[7]  = ~cfg[CFG_SERIAL_INTERRUPT_LINE_BIT];
        s[8]  = cfg[CFG_THERMAL_ALARM_INPUT_BIT];
        s[9]  = cfg[CFG_BATTERY_LOW_INPUT_BIT];
        s[10] = cfg[CFG_LID_BIT];
        s[11] = cfg[CFG_ALERT_BIT];
        s[12] = cfg[CFG_RING_BIT];
        return s;
    endfunction

    // one bit per output pin, high when the pin follows the drive word
    function automatic logic [NUM_GPO-1:0] gpo_select(
        input logic [31:0] cfg,
        input logic        ext_apic
    );
        logic [NUM_GPO-1:0] s;
        s = '1;
        for (int k = 1; k < 8; k++) begin
            s[k] = (cfg[CFG_EIO_BIT] == EIO_SEL);
        end
        for (int k = 0; k < 3; k++) begin
            s[9+k] = ~cfg[CFG_DMA_LO_BIT+k];
        end
        s[14:12] = {3{~ext_apic}};
        s[16:15] = {2{cfg[CFG_SUSBC_BIT]}};
        s[17] = cfg[CFG_CPUSTP_BIT];
        s[18] = cfg[CFG_PCISTP_BIT];
        s[19] = cfg[CFG_SLEEP_BIT];
        s[20] = cfg[CFG_STAT1_BIT];
        s[21] = cfg[CFG_STAT2_BIT];
        s[23:22] = {2{cfg[CFG_XBUS_BIT]}};
        return s;
    endfunction

    localparam logic [NUM_GPO-1:0] GPO_DEFAULT_MASK =
        gpo_select(CFG_RESET, 1'b0);
endpackage
`default_nettype wire

// file: rtl/gpi_input_sync.sv
// two-flop synchroniser for all general-purpose input pins
// assumes pins are asynchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module gpi_input_sync
    import gpio_mux_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    // pins in, settled levels out
    input  wire logic [NUM_GPI-1:0] pin_raw,
    output var  logic [NUM_GPI-1:0] pin_stable
);
    sync_state_t st_q;
    sync_state_t st_d;

    // meta stage feeds only the stable stage
    always_comb begin
        st_d        = st_q;
        st_d.meta   = pin_raw;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q <= '{meta: SYNC_RESET, stable: SYNC_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_stable = st_q.stable;
endmodule
`default_nettype wire

// file: rtl/general_purpose_io_pin_mux.sv
// general-purpose input/output pin mux with its two pm i/o registers
// assumes config words come registered from their owners, and that
// the i/o port offset is already relative to the pm i/o base
`timescale 1ns/1ns
`default_nettype none
module general_purpose_io_pin_mux
    import gpio_mux_pkg::*;
#(
    parameter logic [31:0] DRIVE_INIT = DRIVE_RESET
)(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    // pm i/o register port
    input  wire logic               io_sel,
    input  wire logic               io_write,
    input  wire logic [7:0]         io_addr,
    input  wire logic [3:0]         io_be,
    input  wire logic [31:0]        io_wdata,
    output var  logic [31:0]        io_rdata,
    output var  logic               io_ready,
    // configuration from elsewhere in the bridge
    input  wire logic [31:0]        gen_config,
    input  wire logic               xbus_ext_apic,
    input  wire logic               core_power_good,
    // pins
    input  wire logic [NUM_GPI-1:0] gpi_pin,
    output var  logic [NUM_GPO-1:0] gpo_pin,
    // alternate function side
    input  wire alt_out_t           alt_out,
    output var  alt_in_t            alt_in,
    output var  logic               pm_input1_low
);
    typedef struct packed {
        logic [31:0]        cfg;
        logic               ext_apic;
        logic [NUM_DRIVE-1:0] drive;
        logic [NUM_GPO-1:0] pins;
        logic [NUM_GPI-1:0] level;
        alt_in_t            alt_in;
        logic               in1_low;
        logic [31:0]        rdata;
        logic               ready;
    } mux_state_t;

    localparam mux_state_t STATE_RESET = '{
        cfg:      CFG_RESET,
        ext_apic: 1'b0,
        drive:    DRIVE_INIT[NUM_DRIVE-1:0],
        pins:     DRIVE_INIT[NUM_GPO-1:0] & GPO_DEFAULT_MASK,
        level:    SYNC_RESET,
        alt_in:   ALT_IN_IDLE,
        in1_low:  1'b1,
        rdata:    DATA_RESET,
        ready:    1'b0
    };

    mux_state_t         st_q;
    mux_state_t         st_d;
    logic [NUM_GPI-1:0] in_stable;
    logic [NUM_GPI-1:0] in_sel;
    logic [NUM_GPO-1:0] out_sel;
    logic [NUM_GPO-1:0] alt_pins;

    gpi_input_sync u_sync (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .pin_raw    (gpi_pin),
        .pin_stable (in_stable)
    );

    // alternate output values placed at their pin positions
    function automatic logic [NUM_GPO-1:0] alt_to_pins(input alt_out_t a);
        logic [NUM_GPO-1:0] v;
        v        = '0;
        v[7:1]   = a.upper_isa_address_lines;
        v[11:9]  = a.dma_grant;
        v[12]    = a.ext_intr_ctrl_acknowledge;
        v[13]    = a.ext_intr_ctrl_chip_select;
        v[14]    = a.timer_interrupt_output;
        v[15]    = a.suspend_plane_b_control;
        v[16]    = a.suspend_plane_c_control;
        v[17]    = a.processor_clock_stop;
        v[18]    = a.bus_clock_stop;
        v[19]    = a.cache_sram_sleep;
        v[20]    = a.suspend_status_one;
        v[21]    = a.suspend_status_two;
        v[22]    = a.xbus_transceiver_direction;
        v[23]    = a.xbus_transceiver_output_enable;
        return v;
    endfunction

    // unselected alternate inputs rest at their inactive high level
    function automatic alt_in_t route_alt(
        input logic [NUM_GPI-1:0] p,
        input logic [NUM_GPI-1:0] s
    );
        logic [NUM_GPI-1:0] q;
        alt_in_t            r;
        q = p | s;
        r.io_channel_check           = q[0];
        r.dma_request                = q[4:2];
        r.ext_intr_ctrl_request      = q[5];
        r.clock_chip_interrupt_input = q[6];
        r.serial_interrupt_line      = q[7];
        r.thermal_alarm_input        = q[8];
        r.battery_low_input          = q[9];
        r.lid_switch_input           = q[10];
        r.smbus_alert_input          = q[11];
        r.ring_indicate_input        = q[12];
        return r;
    endfunction

    // selects come from the registered config, so a config change lands two
    // clocks later on the pins; that keeps pin glitches off bus timing
    assign in_sel   = gpi_select(st_q.cfg, st_q.ext_apic);
    assign out_sel  = gpo_select(st_q.cfg, st_q.ext_apic);
    assign alt_pins = alt_to_pins(alt_out);

    always_comb begin
        st_d          = st_q;
        st_d.cfg      = gen_config;
        st_d.ext_apic = xbus_ext_apic;
        st_d.ready    = io_sel;
        // shared inputs read zero while owned by their function
        st_d.level    = in_stable & in_sel;
        st_d.in1_low  = ~in_stable[1];
        st_d.alt_in   = route_alt(in_stable, in_sel);
        // register writes, byte lanes honoured
        if (io_sel && io_write && io_addr == OUT_DRIVE_OFS) begin
            for (int b = 0; b < 4; b++) begin
                if (io_be[b]) begin
                    for (int i = 0; i < 8; i++) begin
                        if (8*b + i < NUM_DRIVE) begin
                            st_d.drive[8*b+i] = io_wdata[8*b+i];
                        end
                    end
                end
            end
        end
        // reads answer one clock later; unmapped offsets read zero
        st_d.rdata = DATA_RESET;
        if (io_sel && !io_write) begin
            if (io_addr == IN_LEVEL_OFS) begin
                st_d.rdata[NUM_GPI-1:0] = st_q.level;
            end else if (io_addr == OUT_DRIVE_OFS) begin
                st_d.rdata[NUM_DRIVE-1:0] = st_q.drive;
            end
        end
        // pins: drive word where selected, else the alt function
        for (int i = 0; i < NUM_GPO; i++) begin
            if (out_sel[i]) begin
                st_d.pins[i] = st_q.drive[i];
            end else begin
                st_d.pins[i] = alt_pins[i];
            end
        end
        // other buffers lose power; only output 8 has a defined level
        if (!core_power_good) begin
            st_d.pins[8] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q <= STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign io_rdata      = st_q.rdata;
    assign io_ready      = st_q.ready;
    assign gpo_pin       = st_q.pins;
    assign alt_in        = st_q.alt_in;
    assign pm_input1_low = st_q.in1_low;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_input_read: assert property (
        io_sel && !io_write && io_addr == IN_LEVEL_OFS |=>
        io_ready && io_rdata[NUM_GPI-1:0] == $past(st_q.level) &&
        io_rdata[31:NUM_GPI] == '0)
        else $error("input level read returned wrong data");

    a_drive_write: assert property (
        io_sel && io_write && io_addr == OUT_DRIVE_OFS &&
        io_be == 4'hf |=>
        st_q.drive == $past(io_wdata[NUM_DRIVE-1:0]))
        else $error("drive word not stored");

    a_pin0_follows: assert property (
        ##1 $stable(st_q.drive) && core_power_good |=>
        gpo_pin[0] == $past(st_q.drive[0]))
        else $error("output 0 does not follow drive word");

    // a pin edge at t+1 comes from drive and select at t against t-1
    a_gp_pin_steady: assert property (
        $stable(st_q.drive) && $stable(st_q.cfg) &&
        core_power_good && out_sel[5] |=> $stable(gpo_pin[5]))
        else $error("gp output moved without a write");

    a_alt_pin_follows: assert property (
        !st_q.cfg[CFG_SUSBC_BIT] && core_power_good |=>
        gpo_pin[15] == $past(alt_out.suspend_plane_b_control))
        else $error("alt-default output not following function");

    a_power_loss: assert property (
        !core_power_good |=> gpo_pin[8] == 1'b0)
        else $error("output 8 not low on power loss");

    a_io_check_mux: assert property (
        st_q.cfg[CFG_EIO_BIT] != EIO_SEL |=>
        st_q.level[0] == 1'b0 &&
        alt_in.io_channel_check == $past(in_stable[0]))
        else $error("input 0 not routed to channel check");

    a_input1_low: assert property (
        ##1 pm_input1_low == ~st_q.level[1])
        else $error("input 1 low flag mismatch");

    a_grant_sel: assert property (
        st_q.cfg[CFG_DMA_LO_BIT+1] && core_power_good |=>
        gpo_pin[10] == $past(alt_out.dma_grant[1]))
        else $error("grant not on output 10");

    a_cfg_next: assert property (
        gen_config[CFG_XBUS_BIT] && core_power_good |=>
        ##1 gpo_pin[22] == $past(st_q.drive[22]))
        else $error("select change late on output 22");
endmodule
`default_nettype wire

// file: dv/board_model.sv
// board side of the pin mux: pin levels and alternate-function values
// assumes the bench sets the wanted levels; pins move off the clock edge
`timescale 1ns/1ns
`default_nettype none
module board_model
    import gpio_mux_pkg::*;
(
    // clock
    input  wire logic               clk_sys,
    // wanted levels
    input  wire logic [NUM_GPI-1:0] level,
    input  wire alt_out_t           want,
    // towards the block
    output var  logic [NUM_GPI-1:0] gpi_pin,
    output var  alt_out_t           alt_out
);
    initial begin
        gpi_pin = '1;
        alt_out = '0;
    end
    // falling edge, so pins are not aligned to the sampling edge
    always @(negedge clk_sys) begin
        gpi_pin <= level;
        alt_out <= want;
    end
endmodule
`default_nettype wire

// file: dv/general_purpose_io_pin_mux_bench.sv
// self-checking bench for the general-purpose pin mux
// assumes the board model feeds the pins; drive reset set non-zero
`timescale 1ns/1ns
`default_nettype none
module general_purpose_io_pin_mux_bench;
    import gpio_mux_pkg::*;
    localparam logic [31:0] INIT = 32'h0000_2c35;
    logic               clk_sys, reset_n, io_sel, io_write, io_ready;
    logic               xbus_ext_apic, core_power_good, pm_input1_low;
    logic [7:0]         io_addr;
    logic [3:0]         io_be;
    logic [31:0]        io_wdata, io_rdata, gen_config, rd;
    logic [NUM_GPI-1:0] gpi_pin, level;
    logic [NUM_GPO-1:0] gpo_pin;
    alt_out_t           alt_out, want;
    alt_in_t            alt_in;
    int                 fail_count, check_count;
    // select table: config word, gp output mask, gp input mask
    localparam logic [31:0] TC [20] = '{32'h0, 32'h1, 32'h100, 32'h200,
        32'h400, 32'h0, 32'h4000, 32'h10000, 32'h20000, 32'h40000,
        32'h80000, 32'h100000, 32'h200000, 32'h400000, 32'h10000000,
        32'h800000, 32'h1000000, 32'h2000000, 32'h8000, 32'h8000000};
    localparam logic [23:0] TO [20] = '{24'h007fff, 24'h007f01,
        24'h007dff, 24'h007bff, 24'h0077ff, 24'h000fff, 24'h007fff,
        24'h007fff, 24'h01ffff, 24'h027fff, 24'h047fff, 24'h087fff,
        24'h107fff, 24'h207fff, 24'hc07fff, 24'h007fff, 24'h007fff,
        24'h007fff, 24'h007fff, 24'h007fff};
    localparam logic [21:0] TI [20] = '{22'h3fe0ff, 22'h3fe0fe,
        22'h3fe0fb, 22'h3fe0f7, 22'h3fe0ef, 22'h3fe0df, 22'h3fe0bf,
        22'h3fe07f, 22'h3fe0ff, 22'h3fe0ff, 22'h3fe0ff, 22'h3fe0ff,
        22'h3fe0ff, 22'h3fe0ff, 22'h3fe0ff, 22'h3fe1ff, 22'h3fe2ff,
        22'h3fe4ff, 22'h3fe8ff, 22'h3ff0ff};

    general_purpose_io_pin_mux #(.DRIVE_INIT(INIT)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .io_sel(io_sel),
        .io_write(io_write), .io_addr(io_addr), .io_be(io_be),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ready(io_ready),
        .gen_config(gen_config), .xbus_ext_apic(xbus_ext_apic),
        .core_power_good(core_power_good), .gpi_pin(gpi_pin),
        .gpo_pin(gpo_pin), .alt_out(alt_out), .alt_in(alt_in),
        .pm_input1_low(pm_input1_low));
    board_model board (.clk_sys(clk_sys), .level(level), .want(want),
        .gpi_pin(gpi_pin), .alt_out(alt_out));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one strobe cycle; ready is a pulse, so a lost answer ends the run
    task automatic io_do(input logic w, input logic [7:0] a,
                         input logic [3:0] be, input logic [31:0] d);
        int n;
        n = 0;
        io_sel = 1'b1;
        io_write = w;
        io_addr = a;
        io_be = be;
        io_wdata = d;
        cyc(1);
        io_sel = 1'b0;
        while (io_ready !== 1'b1 && n < 4) begin
            cyc(1);
            n++;
        end
        if (n == 4) begin
            fail_count++;
            wrap_up();
        end
        rd = io_rdata;
        cyc(1);
    endtask

    // gp-default outputs take the drive reset value and hold still
    task automatic reset_view;
        logic [23:0] first;
        cyc(2);
        first = {want.xbus_transceiver_output_enable,
                 want.xbus_transceiver_direction, want.suspend_status_two,
                 want.suspend_status_one, want.cache_sram_sleep,
                 want.bus_clock_stop, want.processor_clock_stop,
                 want.suspend_plane_c_control, want.suspend_plane_b_control,
                 INIT[14:0]};
        chk({8'h00, gpo_pin}, {8'h00, first});
        want = alt_out_t'(22'h3ffe00);
        repeat (6) begin
            cyc(1);
            chk({17'h0, gpo_pin[14:0]}, {17'h0, INIT[14:0]});
        end
        chk({23'h0, gpo_pin[23:15]}, 32'h0);
        io_do(1'b0, 8'h34, 4'hf, 32'h0);
        chk(rd, INIT);
    endtask

    task automatic reg_access;
        io_do(1'b1, 8'h34, 4'hf, 32'hffff_ffff);
        io_do(1'b0, 8'h34, 4'h0, 32'h0);
        chk(rd, 32'h7fff_ffff);
        io_do(1'b1, 8'h34, 4'h2, 32'h0);
        io_do(1'b1, 8'h30, 4'hf, 32'h0);
        io_do(1'b0, 8'h34, 4'h0, 32'h0);
        chk(rd, 32'h7fff_00ff);
        io_do(1'b0, 8'h38, 4'h0, 32'h0);
        chk(rd, 32'h0);
        io_do(1'b1, 8'h34, 4'hf, 32'h7fff_ffff);
        cyc(1);
        chk({8'h00, gpo_pin}, 32'h0000_7fff);
    endtask

    // every shared pin handed to its alternate function
    task automatic all_alt;
        logic [21:0] p;
        p = 22'h2a5c93;
        level = p;
        want = alt_out_t'(22'h2b4c69);
        gen_config = 32'h0001_4701;
        xbus_ext_apic = 1'b1;
        cyc(6);
        chk({8'h00, gpo_pin}, {8'h00, want.xbus_transceiver_output_enable,
            want.xbus_transceiver_direction, want.suspend_status_two,
            want.suspend_status_one, want.cache_sram_sleep,
            want.bus_clock_stop, want.processor_clock_stop,
            want.suspend_plane_c_control, want.suspend_plane_b_control,
            want.timer_interrupt_output, want.ext_intr_ctrl_chip_select,
            want.ext_intr_ctrl_acknowledge, want.dma_grant, 1'b1,
            want.upper_isa_address_lines, 1'b1});
        chk({20'h0, alt_in}, {20'h0, p[0], p[4:2], p[5], p[6], p[7], p[8],
            p[9], p[10], p[11], p[12]});
        chk({31'h0, pm_input1_low}, {31'h0, ~p[1]});
        io_do(1'b0, 8'h30, 4'h0, 32'h0);
        chk(rd, {10'h0, p & 22'h3fe002});
    endtask

    task automatic sel_table;
        level = '1;
        want = '0;
        for (int i = 0; i < 20; i++) begin
            gen_config = TC[i];
            xbus_ext_apic = (i == 5);
            cyc(6);
            chk({8'h00, gpo_pin}, {8'h00, TO[i]});
            io_do(1'b0, 8'h30, 4'h0, 32'h0);
            chk(rd, {10'h0, TI[i]});
        end
    endtask

    // losing core power pulls output 8 low only
    task automatic power_loss;
        gen_config = 32'h0;
        xbus_ext_apic = 1'b0;
        cyc(4);
        core_power_good = 1'b0;
        cyc(2);
        chk({8'h00, gpo_pin}, 32'h0000_7eff);
        core_power_good = 1'b1;
        cyc(2);
        chk({8'h00, gpo_pin}, 32'h0000_7fff);
    endtask

    initial begin
        fail_count = 0;
        check_count = 0;
        reset_n = 1'b0;
        {io_sel, io_write, io_addr, io_be, io_wdata} = '0;
        gen_config = 32'h0;
        xbus_ext_apic = 1'b0;
        core_power_good = 1'b1;
        level = '1;
        want = alt_out_t'(22'h1b2a5c);
        cyc(5);
        reset_n = 1'b1;
        reset_view();
        reg_access();
        all_alt();
        sel_table();
        power_loss();
        wrap_up();
    end
endmodule
`default_nettype wire
